// ===== rtl/rfs_rx_flow.sv
`timescale 1ns/1ps
`default_nettype none
module rfs_rx_flow (
  // Clock and reset.
  input  wire logic            mclk,
  input  wire logic            rst_n,
  // Register port.
  input  wire rfs_pkg::rfs_req_s req,
  output logic [7:0]           rdata,
  // Receive side events.
  input  wire logic            rx_char_stb,
  input  wire logic            rx_char_read,
  // Link flow control.
  input  wire logic            cts_n,
  output logic                 rts_n,
  output logic                 send_stop_stb,
  output logic                 send_resume_stb,
  output logic                 tx_hold,
  // Interrupt.
  output logic                 irq
);
  import rfs_pkg::*;

  // ****************************************************************
  // Storage.
  // ****************************************************************
  logic [7:0]             ctrl_ff;
  logic [7:0]             upper_ff;
  logic [7:0]             lower_ff;
  logic [2:0]             ien_ff;
  logic [2:0]             istat_ff;
  logic [8:0]             count_ff;
  logic [7:0]             rdata_ff;
  rfs_flow_e              hw_ff;
  rfs_flow_e              sw_ff;
  logic                   stop_ff;
  logic                   resume_ff;
  logic [8:0]             nxt_count;
  logic [8:0]             depth;
  logic                   fifo_en;
  logic                   hw_en;
  logic                   sw_en;
  logic                   cts_en;
  logic                   full;
  logic                   push;
  logic                   pop;
  logic                   drop;
  logic                   above;
  logic                   at_or_below;
  logic                   hw_set;
  logic                   hw_clr;
  logic                   sw_set;
  logic                   sw_clr;
  logic [2:0]             events;
  logic [7:0]             flow_view;
  logic [7:0]             level_view;
  logic [7:0]             istat_view;

  // ****************************************************************
  // Mode decode.
  // ****************************************************************

  // Enables from the control register.
  assign fifo_en = ctrl_ff[RFS_CTRL_FIFO_EN];
  assign hw_en   = fifo_en & ctrl_ff[RFS_CTRL_AUTO_RTS];
  assign sw_en   = fifo_en & ctrl_ff[RFS_CTRL_SW_FLOW];
  assign cts_en  = fifo_en & ctrl_ff[RFS_CTRL_AUTO_CTS];
  assign depth   = ctrl_ff[RFS_CTRL_DEEP] ? RFS_DEPTH_DEEP : RFS_DEPTH_SHALLOW;

  // ****************************************************************
  // Occupancy count.
  // ****************************************************************

  // A character is kept only while there is room; otherwise it is lost.
  assign full = (count_ff >= depth);
  assign push = rx_char_stb & ~full;
  assign drop = rx_char_stb & full;
  assign pop  = rx_char_read & (count_ff != 9'h000);

  // Next count with simultaneous store and read.
  always_comb begin
    nxt_count = count_ff;
    if (push && !pop) begin
      nxt_count = count_ff + 9'h001;
    end else if (pop && !push) begin
      nxt_count = count_ff - 9'h001;
    end
  end

  // Count register; a change between the shallow and the deep mode empties it.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      count_ff <= 9'h000;
    end else if (req.wr && req.addr == RFS_ADDR_CTRL &&
                 req.wdata[RFS_CTRL_DEEP] != ctrl_ff[RFS_CTRL_DEEP]) begin
      count_ff <= 9'h000;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // ****************************************************************
  // Threshold comparison with hysteresis.
  // ****************************************************************
  assign above       = (count_ff > {1'b0, upper_ff});
  assign at_or_below = (count_ff <= {1'b0, lower_ff});

  assign hw_set = hw_en & (hw_ff == RFS_RUN) & above;
  assign hw_clr = hw_en & (hw_ff == RFS_PAUSE) & at_or_below;
  assign sw_set = sw_en & (sw_ff == RFS_RUN) & above;
  assign sw_clr = sw_en & (sw_ff == RFS_PAUSE) & at_or_below;

  // Hardware pause state drives the request-to-send line.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hw_ff <= RFS_RUN;
    end else begin
      case (hw_ff)
        RFS_RUN: begin
          if (hw_set) begin
            hw_ff <= RFS_PAUSE;
          end
        end
        RFS_PAUSE: begin
          if (!hw_en || hw_clr) begin
            hw_ff <= RFS_RUN;
          end
        end
        default: begin
          hw_ff <= RFS_RUN;
        end
      endcase
    end
  end

  // Software pause state emits stop and resume character requests.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sw_ff <= RFS_RUN;
    end else begin
      case (sw_ff)
        RFS_RUN: begin
          if (sw_set) begin
            sw_ff <= RFS_PAUSE;
          end
        end
        RFS_PAUSE: begin
          if (!sw_en || sw_clr) begin
            sw_ff <= RFS_RUN;
          end
        end
        default: begin
          sw_ff <= RFS_RUN;
        end
      endcase
    end
  end

  // One-cycle requests to the transmitter for stop and resume characters.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stop_ff   <= 1'b0;
      resume_ff <= 1'b0;
    end else begin
      stop_ff   <= sw_set;
      resume_ff <= sw_clr;
    end
  end

  assign send_stop_stb   = stop_ff;
  assign send_resume_stb = resume_ff;
  assign rts_n           = hw_en & (hw_ff == RFS_PAUSE);
  assign tx_hold         = cts_en & cts_n;

  // ****************************************************************
  // Configuration registers.
  // ****************************************************************

  // Writable registers.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_ff  <= RFS_CTRL_RST;
      upper_ff <= RFS_UPPER_RST;
      lower_ff <= RFS_LOWER_RST;
      ien_ff   <= RFS_IEN_RST;
    end else if (req.wr) begin
      case (req.addr)
        RFS_ADDR_CTRL:  ctrl_ff  <= {3'h0, req.wdata[4:0]};
        RFS_ADDR_UPPER: upper_ff <= req.wdata;
        RFS_ADDR_LOWER: lower_ff <= req.wdata;
        RFS_ADDR_IEN:   ien_ff   <= req.wdata[2:0];
        default:        ctrl_ff  <= ctrl_ff;
      endcase
    end
  end

  // ****************************************************************
  // Interrupts.
  // ****************************************************************
  assign events[RFS_EVT_PAUSE]  = hw_set | sw_set;
  assign events[RFS_EVT_RESUME] = hw_clr | sw_clr;
  assign events[RFS_EVT_DROP]   = drop;

  // Sticky bits; an event in the clearing cycle wins over the clear.
  generate
    for (genvar i = 0; i < RFS_EVT_NUM; i++) begin : g_evt
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          istat_ff[i] <= 1'b0;
        end else if (events[i]) begin
          istat_ff[i] <= 1'b1;
        end else if (req.wr && req.addr == RFS_ADDR_ICLR && req.wdata[i]) begin
          istat_ff[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq = |(istat_ff & ien_ff);

  // ****************************************************************
  // Read views.
  // ****************************************************************

  // Level shows seven bits in the shallow mode, eight in the deep mode.
  assign level_view = ctrl_ff[RFS_CTRL_DEEP] ? count_ff[7:0]
                                             : {1'b0, count_ff[6:0]};

  // Flow status; unused pairs stay zero.
  always_comb begin
    flow_view = 8'h00;
    flow_view[RFS_FLOW_HW_PAUSE] = hw_en & (hw_ff == RFS_PAUSE);
    flow_view[RFS_FLOW_SW_PAUSE] = sw_en & (sw_ff == RFS_PAUSE);
    flow_view[RFS_FLOW_CTS_HOLD] = cts_en & cts_n;
  end

  // Interrupt status carries the ninth count bit in the deep mode.
  always_comb begin
    istat_view = {5'h00, istat_ff};
    istat_view[RFS_ISTAT_CNT_MSB] = ctrl_ff[RFS_CTRL_DEEP] & count_ff[8];
  end

  // Read data stand in the cycle after the strobe only.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        RFS_ADDR_LEVEL: rdata_ff <= level_view;
        RFS_ADDR_FLOW:  rdata_ff <= flow_view;
        RFS_ADDR_ISTAT: rdata_ff <= istat_view;
        RFS_ADDR_IEN:   rdata_ff <= {5'h00, ien_ff};
        RFS_ADDR_CTRL:  rdata_ff <= ctrl_ff;
        RFS_ADDR_UPPER: rdata_ff <= upper_ff;
        RFS_ADDR_LOWER: rdata_ff <= lower_ff;
        default:        rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign rdata = rdata_ff;

endmodule : rfs_rx_flow
`default_nettype wire

// ===== shared/rfs_pkg.sv
`default_nettype none
package rfs_pkg;

  // ****************************************************************
  // Register map, one byte per address.
  // ****************************************************************
  localparam logic [3:0] RFS_ADDR_LEVEL  = 4'h0;  // rx_fifo_level, read only.
  localparam logic [3:0] RFS_ADDR_FLOW   = 4'h1;  // flow_state, read only.
  localparam logic [3:0] RFS_ADDR_ISTAT  = 4'h2;  // interrupt_status_reg, read only.
  localparam logic [3:0] RFS_ADDR_ICLR   = 4'h3;  // Interrupt clear, write only.
  localparam logic [3:0] RFS_ADDR_IEN    = 4'h4;  // Interrupt enable, read and write.
  localparam logic [3:0] RFS_ADDR_CTRL   = 4'h5;  // Flow control setup, read and write.
  localparam logic [3:0] RFS_ADDR_UPPER  = 4'h6;  // upper_fill_threshold.
  localparam logic [3:0] RFS_ADDR_LOWER  = 4'h7;  // lower_fill_threshold.

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int RFS_CTRL_FIFO_EN   = 0;
  localparam int RFS_CTRL_DEEP      = 1;  // 1 selects the 256-entry mode.
  localparam int RFS_CTRL_AUTO_RTS  = 2;
  localparam int RFS_CTRL_SW_FLOW   = 3;
  localparam int RFS_CTRL_AUTO_CTS  = 4;
  localparam int RFS_FLOW_HW_PAUSE  = 5;
  localparam int RFS_FLOW_SW_PAUSE  = 4;
  localparam int RFS_FLOW_CTS_HOLD  = 1;
  localparam int RFS_ISTAT_CNT_MSB  = 6;
  localparam int RFS_EVT_PAUSE      = 0;
  localparam int RFS_EVT_RESUME     = 1;
  localparam int RFS_EVT_DROP       = 2;
  localparam int RFS_EVT_NUM        = 3;

  // ****************************************************************
  // Depths and reset values.
  // ****************************************************************
  localparam logic [8:0] RFS_DEPTH_SHALLOW = 9'h040;
  localparam logic [8:0] RFS_DEPTH_DEEP    = 9'h100;
  localparam logic [7:0] RFS_CTRL_RST      = 8'h00;
  localparam logic [7:0] RFS_UPPER_RST     = 8'h38;
  localparam logic [7:0] RFS_LOWER_RST     = 8'h08;
  localparam logic [2:0] RFS_IEN_RST       = 3'h0;

  // Register port request.
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rfs_req_s;

  // Pause state of one flow control method.
  typedef enum logic [0:0] {
    RFS_RUN   = 1'b0,
    RFS_PAUSE = 1'b1
  } rfs_flow_e;

endpackage : rfs_pkg
`default_nettype wire

// ===== test/rfs_remote.sv
`timescale 1ns/1ps
`default_nettype none
module rfs_remote (
  // Link from the block.
  input  wire logic mclk,
  input  wire logic rts_n,
  input  wire logic send_stop_stb,
  input  wire logic send_resume_stb,
  // Scenario control and link to the block.
  input  wire logic want,
  input  wire logic busy,
  output logic      rx_char_stb = 1'b0,
  output logic      cts_n,
  output int        sent = 0
);
  logic xoff_ff = 1'b0;
  // Remembers a stop character until the resume character or idle.
  always_ff @(posedge mclk) begin
    if (send_stop_stb) xoff_ff <= 1'b1;
    else if (send_resume_stb || !want) xoff_ff <= 1'b0;
  end
  // Sends one character a cycle unless either pause is seen.
  always_ff @(posedge mclk) begin
    rx_char_stb <= want && !rts_n && !xoff_ff && !send_stop_stb;
    sent <= sent + int'(rx_char_stb);
  end
  assign cts_n = busy;
endmodule : rfs_remote
`default_nettype wire

// ===== test/rfs_rx_flow_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module rfs_rx_flow_monitor
  import rfs_pkg::*;
(
  input wire logic mclk, rst_n,
  input wire rfs_req_s req,
  input wire logic [7:0] rdata,
  input wire logic rx_char_stb, rx_char_read, cts_n, rts_n,
  input wire logic send_stop_stb, send_resume_stb, tx_hold, irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // A register read of one address.
  sequence s_rd(logic [3:0] a);
    req.rd && req.addr == a;
  endsequence
  a_rdata_idle: assert property (!req.rd |=> rdata == 8'h00) else $error("stray read data");
  a_unmapped_zero: assert property (req.rd && req.addr[3] |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_flow_spare: assert property (s_rd(RFS_ADDR_FLOW) |=> rdata[7:6] == 2'h0 && rdata[3:2] == 2'h0)
    else $error("spare flow bits set");
  a_hw_pause_bit: assert property (s_rd(RFS_ADDR_FLOW) |=> rdata[5] == $past(rts_n))
    else $error("pause bit differs from rts");
  a_cts_bit: assert property (s_rd(RFS_ADDR_FLOW) |=> rdata[1] == $past(tx_hold))
    else $error("cts bit differs from hold");
  a_hold_needs_cts: assert property (tx_hold |-> cts_n) else $error("hold with cts low");
  a_stop_single: assert property (send_stop_stb |=> !send_stop_stb) else $error("long stop");
  a_strobes_apart: assert property (!(send_stop_stb && send_resume_stb))
    else $error("stop and resume together");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(req.wr)) else $error("irq fell alone");
endmodule : rfs_rx_flow_monitor
bind rfs_rx_flow rfs_rx_flow_monitor u_rfs_rx_flow_monitor (.mclk(mclk), .rst_n(rst_n),
  .req(req), .rdata(rdata), .rx_char_stb(rx_char_stb), .rx_char_read(rx_char_read),
  .cts_n(cts_n), .rts_n(rts_n), .send_stop_stb(send_stop_stb),
  .send_resume_stb(send_resume_stb), .tx_hold(tx_hold), .irq(irq));
`default_nettype wire

// ===== test/test_rfs_rx_flow.sv
`timescale 1ns/1ps
`default_nettype none
module test_rfs_rx_flow;
  import rfs_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  rfs_req_s req = '0;
  logic rx_char_read = 1'b0;
  logic want = 1'b0;
  logic busy = 1'b0;
  logic [7:0] rdata, v;
  logic rx_char_stb, cts_n, rts_n, stop_stb, resume_stb, tx_hold, irq;
  int sent, s0, failures = 0, samples_checked = 0, stops = 0, resumes = 0;
  // Clock of 50 ns period.
  initial begin
    forever #25 mclk = ~mclk;
  end
  rfs_rx_flow u_rfs_rx_flow (.mclk(mclk), .rst_n(rst_n), .req(req), .rdata(rdata),
    .rx_char_stb(rx_char_stb), .rx_char_read(rx_char_read), .cts_n(cts_n), .rts_n(rts_n),
    .send_stop_stb(stop_stb), .send_resume_stb(resume_stb), .tx_hold(tx_hold), .irq(irq));
  rfs_remote u_rfs_remote (.mclk(mclk), .rts_n(rts_n), .send_stop_stb(stop_stb),
    .send_resume_stb(resume_stb), .want(want), .busy(busy), .rx_char_stb(rx_char_stb),
    .cts_n(cts_n), .sent(sent));
  // Counts stop and resume requests.
  always @(posedge mclk) begin
    stops <= stops + int'(stop_stb);
    resumes <= resumes + int'(resume_stb);
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 v = rdata;
  endtask : rd
  task automatic pop(input int n);
    repeat (n) begin
      @(posedge mclk);
      rx_char_read <= 1'b1;
      @(posedge mclk);
      rx_char_read <= 1'b0;
    end
  endtask : pop
  task automatic fill(input int n);
    s0 = sent;
    @(posedge mclk);
    want <= 1'b1;
    repeat (n) @(posedge mclk);
    want <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
  endtask : fill
  task automatic t_basic;
    wr(RFS_ADDR_LEVEL, 8'hFF);
    rd(RFS_ADDR_LEVEL);
    chk(v, 9'h000);
    rd(4'hF);
    chk(v, 9'h000);
    wr(RFS_ADDR_CTRL, 8'h01);
    fill(70);
    rd(RFS_ADDR_LEVEL);
    chk(v, 9'h040);
    rd(RFS_ADDR_FLOW);
    chk(v, 9'h000);
    rd(RFS_ADDR_ISTAT);
    chk({v[6], v[2:0]}, 9'h004);
    pop(64);
    rd(RFS_ADDR_LEVEL);
    chk(v, 9'h000);
    wr(RFS_ADDR_ICLR, 8'h07);
    $display("t_basic done");
  endtask : t_basic
  task automatic t_deep;
    wr(RFS_ADDR_CTRL, 8'h03);
    fill(260);
    rd(RFS_ADDR_ISTAT);
    chk(v[6], 1'b1);
    rd(RFS_ADDR_LEVEL);
    chk(v, 9'h000);
    pop(1);
    rd(RFS_ADDR_ISTAT);
    chk(v[6], 1'b0);
    rd(RFS_ADDR_LEVEL);
    chk(v, 9'h0FF);
    wr(RFS_ADDR_CTRL, 8'h01);
    wr(RFS_ADDR_ICLR, 8'h07);
    $display("t_deep done");
  endtask : t_deep
  task automatic t_hw;
    wr(RFS_ADDR_UPPER, 8'h04);
    wr(RFS_ADDR_LOWER, 8'h02);
    wr(RFS_ADDR_CTRL, 8'h05);
    rd(RFS_ADDR_UPPER);
    chk(v, 9'h004);
    fill(20);
    chk(rts_n, 1'b1);
    rd(RFS_ADDR_FLOW);
    chk(v, 9'h020);
    rd(RFS_ADDR_LEVEL);
    chk(v, 9'(sent - s0));
    pop(int'(v) - 3);
    repeat (3) @(posedge mclk);
    chk(rts_n, 1'b1);
    pop(1);
    repeat (3) @(posedge mclk);
    chk(rts_n, 1'b0);
    fill(20);
    wr(RFS_ADDR_CTRL, 8'h01);
    rd(RFS_ADDR_FLOW);
    chk(v, 9'h000);
    rd(RFS_ADDR_LEVEL);
    pop(int'(v));
    $display("t_hw done");
  endtask : t_hw
  task automatic t_sw;
    int r0;
    int p0;
    r0 = resumes;
    p0 = stops;
    wr(RFS_ADDR_CTRL, 8'h09);
    fill(20);
    chk(9'(stops - p0), 9'h001);
    rd(RFS_ADDR_FLOW);
    chk(v, 9'h010);
    chk(irq, 1'b0);
    wr(RFS_ADDR_IEN, 8'h01);
    #1;
    chk(irq, 1'b1);
    wr(RFS_ADDR_ICLR, 8'h01);
    #1;
    chk(irq, 1'b0);
    wr(RFS_ADDR_CTRL, 8'h01);
    rd(RFS_ADDR_FLOW);
    chk(v, 9'h000);
    wr(RFS_ADDR_CTRL, 8'h09);
    rd(RFS_ADDR_LEVEL);
    pop(int'(v) - 2);
    repeat (3) @(posedge mclk);
    chk(9'(resumes - r0), 9'h001);
    rd(RFS_ADDR_FLOW);
    chk(v, 9'h000);
    $display("t_sw done");
  endtask : t_sw
  task automatic t_cts;
    wr(RFS_ADDR_CTRL, 8'h11);
    busy <= 1'b1;
    rd(RFS_ADDR_FLOW);
    chk({v, tx_hold}, 9'h005);
    busy <= 1'b0;
    rd(RFS_ADDR_FLOW);
    chk({v, tx_hold}, 9'h000);
    wr(RFS_ADDR_CTRL, 8'h01);
    busy <= 1'b1;
    rd(RFS_ADDR_FLOW);
    chk({v, tx_hold}, 9'h000);
    $display("t_cts done");
  endtask : t_cts
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  // Main sequence after a five cycle reset.
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    t_basic;
    t_deep;
    t_hw;
    t_sw;
    t_cts;
    tally_and_finish;
  end
  // Watchdog well beyond the fewer than one thousand cycles needed.
  initial begin
    #2000000;
    failures++;
    tally_and_finish;
  end
endmodule : test_rfs_rx_flow
`default_nettype wire
